/* verilog/srx_top.sv */
// Receive side of an asynchronous serial unit with status flags, wakeup,
// interrupt requests and an AXI4-Lite register slave.
// Assumes the receive line, mode and break inputs are synchronous to CLK_SYS.
//
// What this block does
// RULE1: Missing stop bit sets framing error flag
// RULE2: Break character also sets framing error
// RULE3: Framing error set with receiver full flag
// RULE4: Stop samples: one bad noise, more framing
// RULE5: Realign sample phase on valid falling edges
// RULE6: Stop sampled at tick 154 or 170
// RULE7: Wakeup bit mutes all receiver interrupts
// RULE8: Address mark clears wakeup, sets full flag
// RULE9: Idle wakeup sets neither idle nor full
// RULE10: Idle type selects where ones counting starts
// RULE11: Idle line may end standby at once
// RULE12: Character transfer sets full flag, interrupts
// RULE13: Ten or eleven ones set idle flag
// RULE14: Overrun keeps old data, drops new
// RULE15: Noise in any bit sets noise flag
// RULE16: Parity failure sets parity error flag
// RULE17: Wait mode runs on, registers locked out
// RULE18: Software disables unit before wait if unused
// RULE19: Stop mode halts, no interrupts, keeps state
// RULE20: Break with clear enable lets clears stick
// RULE21: Break without clear enable protects flags
// RULE22: Sample clock sixteen ticks per bit
// RULE23: Idle type one counts after stop bit
// RULE24: Wake method one selects address mark
`timescale 1ns/1ps
module srx_top import srx_pkg::*; (
	input  wire logic        CLK_SYS,            // System clock, 200 MHz
	input  wire logic        ARST_N,             // Async reset, active low
	input  wire logic        RECEIVE_LINE_PIN,   // Serial receive line
	input  wire logic        WAIT_MODE,          // Processor in wait mode
	input  wire logic        STOP_MODE,          // Processor in stop mode
	input  wire logic        DBG_BREAK,          // Debug break state
	input  wire logic        BREAK_CLEAR_ENABLE, // Clears allowed in break
	input  wire logic        S_AXI_AWVALID,      // Write address valid
	output logic             S_AXI_AWREADY,      // Write address ready
	input  wire logic [4:0]  S_AXI_AWADDR,       // Write byte address
	input  wire logic        S_AXI_WVALID,       // Write data valid
	output logic             S_AXI_WREADY,       // Write data ready
	input  wire logic [31:0] S_AXI_WDATA,        // Write data
	input  wire logic [3:0]  S_AXI_WSTRB,        // Write byte strobes
	output logic             S_AXI_BVALID,       // Write response valid
	input  wire logic        S_AXI_BREADY,       // Write response ready
	output logic [1:0]       S_AXI_BRESP,        // Write response
	input  wire logic        S_AXI_ARVALID,      // Read address valid
	output logic             S_AXI_ARREADY,      // Read address ready
	input  wire logic [4:0]  S_AXI_ARADDR,       // Read byte address
	output logic             S_AXI_RVALID,       // Read data valid
	input  wire logic        S_AXI_RREADY,       // Read data ready
	output logic [31:0]      S_AXI_RDATA,        // Read data
	output logic [1:0]       S_AXI_RRESP,        // Read response
	output logic             IRQ_RX,             // Receiver interrupt request
	output logic             IRQ_ERR             // Error interrupt request
);
	// Majority of three samples
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	logic        ensci, mode9, wake, idle_line_type_bit, pen, pty, rie, idle_interrupt_enable, re, receiver_wakeup_bit;
	logic        overrun_interrupt_enable, noise_interrupt_enable, framing_error_interrupt_enable, parity_error_interrupt_enable;
	logic [15:0] baud_div;
	logic        receiver_full_flag, idle_f, ovr_f, noise_f, fe_f, pe_f, r8, arm;
	logic [7:0]  data_reg;
	logic        aw_held, w_held;
	logic [4:0]  aw_a;
	logic [31:0] w_d;
	logic [3:0]  w_s;
	logic        do_wr, wr_ok, rd_hs, rd_status, rd_data, allow_clr, clr;
	logic [15:0] baud_cnt;
	logic        tick, run, rx;
	srx_state_t  st;
	logic [4:0]  rt, rt_n, idle_rt;
	logic [3:0]  bitn, nbits, idle_bits, idle_thr;
	logic [2:0]  smp, s3, hist;
	logic [8:0]  dbits;
	logic        last_bit, nz, resynced, resync, idle_ev, idle_armed;
	logic [7:0]  tick_cnt;
	logic        ch_done, ch_fe, ch_nf, ch_pe, ch_brk;
	logic [8:0]  ch_data;
	logic        ch_msb, take, idle_wake;
	logic [31:0] rd_word;

	assign rx        = RECEIVE_LINE_PIN;
	assign nbits     = mode9 ? 4'h9 : 4'h8;
	assign idle_thr  = mode9 ? IDLE_BITS9 : IDLE_BITS8;
	assign run       = ensci && re && !STOP_MODE;
	assign do_wr     = aw_held && w_held && !S_AXI_BVALID;
	// RULE17: bus locked out in wait
	assign wr_ok     = do_wr && !WAIT_MODE;
	assign rd_hs     = S_AXI_ARVALID && S_AXI_ARREADY && !WAIT_MODE;
	assign rd_status = rd_hs && S_AXI_ARADDR == ADDR_STATUS;
	assign rd_data   = rd_hs && S_AXI_ARADDR == ADDR_DATA;
	// RULE20: clears allowed in break
	assign allow_clr = !DBG_BREAK || BREAK_CLEAR_ENABLE;
	assign clr       = rd_data && arm && allow_clr;
	// RULE22: sixteen ticks per bit
	assign rt_n      = (rt == RT_PER_BIT) ? 5'h01 : rt + 5'h01;
	assign s3        = {smp[1:0], rx};
	// RULE5: valid falling edge after a one
	assign resync    = st == SRX_CHAR && bitn != 4'h0 && last_bit && hist[0] && !rx
		&& (rt_n < RT_S1 || rt_n > RT_S3);

	// Write channel handshakes
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_a          <= 5'h00;
			w_d           <= 32'h0000_0000;
			w_s           <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held       <= 1'b1;
				aw_a          <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held       <= 1'b1;
				w_d          <= S_AXI_WDATA;
				w_s          <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_wr) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (!WAIT_MODE && (aw_a == ADDR_CTRL1 || aw_a == ADDR_CTRL2
					|| aw_a == ADDR_CTRL3 || aw_a == ADDR_BAUD)) ? RESP_OKAY : RESP_SLVERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// Read word selection
	always_comb begin
		rd_word = 32'h0000_0000;
		case (S_AXI_ARADDR)
			ADDR_CTRL1:  rd_word[5:0] = {pty, pen, idle_line_type_bit, wake, mode9, ensci};
			ADDR_CTRL2:  rd_word[3:0] = {receiver_wakeup_bit, re, idle_interrupt_enable, rie};
			ADDR_CTRL3:  rd_word[7:0] = {r8, 3'h0, parity_error_interrupt_enable, framing_error_interrupt_enable, noise_interrupt_enable, overrun_interrupt_enable};
			ADDR_STATUS: rd_word[5:0] = {pe_f, fe_f, noise_f, ovr_f, idle_f, receiver_full_flag};
			ADDR_DATA:   rd_word[7:0] = data_reg;
			ADDR_BAUD:   rd_word[15:0] = baud_div;
			default:     rd_word = 32'h0000_0000;
		endcase
	end

	// Read channel, one-cycle answer
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= WAIT_MODE ? 32'h0000_0000 : rd_word;
			S_AXI_RRESP   <= (WAIT_MODE || S_AXI_ARADDR > ADDR_BAUD || S_AXI_ARADDR[1:0] != 2'h0)
				? RESP_SLVERR : RESP_OKAY;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// Control registers, receiver enable needs the unit enabled
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			{ensci, mode9, wake, idle_line_type_bit, pen, pty} <= 6'h00;
			{rie, idle_interrupt_enable, re, overrun_interrupt_enable, noise_interrupt_enable, framing_error_interrupt_enable, parity_error_interrupt_enable} <= 7'h00;
			baud_div <= BAUD_RST;
		end else if (wr_ok) begin
			if (aw_a == ADDR_CTRL1 && w_s[0]) begin
				ensci <= w_d[C1_ENABLE];
				mode9 <= w_d[C1_MODE9];
				// RULE24: wake method select
				wake  <= w_d[C1_WAKE];
				// RULE23: idle type select
				idle_line_type_bit  <= w_d[C1_IDLE_LINE_TYPE_BIT];
				pen   <= w_d[C1_PEN];
				pty   <= w_d[C1_PTY];
			end
			if (aw_a == ADDR_CTRL2 && w_s[0]) begin
				rie  <= w_d[C2_RIE];
				idle_interrupt_enable <= w_d[C2_IDLE_INTERRUPT_ENABLE];
				if (ensci)
					re <= w_d[C2_RE];
			end
			if (aw_a == ADDR_CTRL3 && w_s[0]) begin
				overrun_interrupt_enable <= w_d[C3_OVERRUN_INTERRUPT_ENABLE];
				noise_interrupt_enable <= w_d[C3_NOISE_INTERRUPT_ENABLE];
				framing_error_interrupt_enable <= w_d[C3_FRAMING_ERROR_INTERRUPT_ENABLE];
				parity_error_interrupt_enable <= w_d[C3_PARITY_ERROR_INTERRUPT_ENABLE];
			end
			if (aw_a == ADDR_BAUD) begin
				if (w_s[0])
					baud_div[7:0] <= w_d[7:0];
				if (w_s[1])
					baud_div[15:8] <= w_d[15:8];
			end
		end
	end

	// Sample clock tick, frozen in stop mode
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (STOP_MODE || !ensci) begin
			tick <= 1'b0;
		end else if (baud_cnt >= baud_div) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// Receiver: start search, bit recovery, idle counting
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			st <= SRX_HUNT;
			{rt, idle_rt, bitn, idle_bits} <= 18'h00000;
			{smp, hist, dbits} <= 15'h0000;
			{last_bit, nz, resynced, idle_ev, ch_done} <= 5'h00;
			{ch_fe, ch_nf, ch_pe, ch_brk} <= 4'h0;
			ch_data  <= 9'h000;
			tick_cnt <= 8'h00;
		end else begin
			idle_ev <= 1'b0;
			ch_done <= 1'b0;
			if (!run) begin
				st <= SRX_HUNT;
			end else if (tick) begin
				hist <= {hist[1:0], rx};
				if (st == SRX_HUNT) begin
					if (!rx && hist == 3'h7) begin
						st <= SRX_CHAR;
						{rt, bitn, tick_cnt} <= {5'h01, 4'h0, 8'h01};
						{nz, resynced, last_bit, idle_rt, idle_bits} <= 12'h000;
					end else if (!rx) begin
						{idle_rt, idle_bits} <= 9'h000;
					end else if (idle_rt == RT_PER_BIT - 5'h01) begin
						// RULE10: ones counted on an idle line
						idle_rt <= 5'h00;
						if (idle_bits != 4'hF)
							idle_bits <= idle_bits + 4'h1;
						if (idle_bits + 4'h1 == idle_thr)
							idle_ev <= 1'b1;
					end else begin
						idle_rt <= idle_rt + 5'h01;
					end
				end else begin
					tick_cnt <= tick_cnt + 8'h01;
					if (resync) begin
						// RULE5: phase realigned to edge
						rt       <= 5'h01;
						last_bit <= 1'b0;
						if (rt_n != 5'h01)
							resynced <= 1'b1;
						if (rt_n > RT_S3 || rt_n == 5'h01)
							bitn <= bitn + 4'h1;
					end else begin
						rt <= rt_n;
						if (rt_n == 5'h01)
							bitn <= bitn + 4'h1;
						if (rt_n >= RT_S1 && rt_n <= RT_S3
							|| bitn == 4'h0 && (rt_n == RT_V1 || rt_n == RT_V2 || rt_n == RT_V3))
							smp <= s3;
						if (bitn == 4'h0 && rt_n == RT_V3) begin
							if (maj3(s3))
								st <= SRX_HUNT;
							else if (s3 != 3'h0)
								nz <= 1'b1;
						end else if (rt_n == RT_S3) begin
							if (bitn == 4'h0) begin
								// RULE15: noise on start bit
								nz <= nz | (s3 != 3'h0);
							end else if (bitn <= nbits) begin
								dbits[bitn - 4'h1] <= maj3(s3);
								last_bit <= maj3(s3);
								nz <= nz | (s3 != 3'h0 && s3 != 3'h7);
								// RULE10: type 0 counts data ones
								if (!idle_line_type_bit && maj3(s3))
									idle_bits <= idle_bits + 4'h1;
								else
									idle_bits <= 4'h0;
							end else begin
								// RULE6: stop bit decided here
								st      <= SRX_HUNT;
								ch_done <= 1'b1;
								ch_data <= mode9 ? dbits : {1'b0, dbits[7:0]};
								// RULE4: mixed samples noise, low majority framing
								ch_nf   <= nz | (s3 != 3'h0 && s3 != 3'h7);
								// RULE1: stop not a one
								ch_fe   <= !maj3(s3);
								// RULE2: all zero character is a break
								ch_brk  <= !maj3(s3) && (mode9 ? dbits : {1'b0, dbits[7:0]}) == 9'h000;
								// RULE16: parity over data bits
								ch_pe   <= pen && ((mode9 ? ^dbits : ^dbits[7:0]) != pty);
								if (!idle_line_type_bit && maj3(s3))
									idle_bits <= idle_bits + 4'h1;
								idle_rt <= 5'h00;
							end
						end
					end
				end
			end
		end
	end

	assign ch_msb    = mode9 ? ch_data[8] : ch_data[7];
	// RULE8: address mark takes character
	assign take      = ch_done && (!receiver_wakeup_bit || wake && ch_msb);
	// RULE11: already idle line ends standby
	assign idle_wake = receiver_wakeup_bit && !wake && idle_bits >= idle_thr;

	// Status flags, data register and standby, set wins over clear
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			{receiver_full_flag, idle_f, ovr_f, noise_f, fe_f, pe_f, r8, arm} <= 8'h00;
			{receiver_wakeup_bit, idle_armed} <= 2'h0;
			data_reg <= 8'h00;
		end else begin
			// RULE21: arm held through protected break
			if (rd_status && allow_clr)
				arm <= 1'b1;
			else if (clr)
				arm <= 1'b0;
			if (clr)
				{receiver_full_flag, idle_f, ovr_f, noise_f, fe_f, pe_f} <= 6'h00;
			if (wr_ok && aw_a == ADDR_CTRL2 && w_s[0] && ensci)
				receiver_wakeup_bit <= w_d[C2_RWU];
			else if (idle_wake || take && receiver_wakeup_bit)
				// RULE9: idle wake leaves flags alone
				receiver_wakeup_bit <= 1'b0;
			if (ch_done)
				idle_armed <= 1'b1;
			if (idle_ev && idle_armed && !receiver_wakeup_bit) begin
				// RULE13: idle flag after ten or eleven ones
				idle_f     <= 1'b1;
				idle_armed <= 1'b0;
			end
			if (take) begin
				if (receiver_full_flag && !clr) begin
					// RULE14: overrun keeps old data
					ovr_f <= 1'b1;
				end else begin
					// RULE12: transfer sets full flag
					receiver_full_flag     <= 1'b1;
					data_reg <= ch_brk ? 8'h00 : ch_data[7:0];
					r8       <= ch_brk ? 1'b0 : ch_msb;
					// RULE3: errors with full flag
					fe_f     <= ch_fe;
					noise_f  <= ch_nf;
					pe_f     <= ch_pe;
				end
			end
		end
	end

	// Interrupt requests, muted in standby and stop mode
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ_RX  <= 1'b0;
			IRQ_ERR <= 1'b0;
		end else begin
			// RULE7: standby mutes requests
			// RULE19: stop mode raises nothing
			IRQ_RX  <= !receiver_wakeup_bit && !STOP_MODE && (receiver_full_flag && rie || idle_f && idle_interrupt_enable);
			IRQ_ERR <= !receiver_wakeup_bit && !STOP_MODE
				&& (ovr_f && overrun_interrupt_enable || noise_f && noise_interrupt_enable || fe_f && framing_error_interrupt_enable || pe_f && parity_error_interrupt_enable);
		end
	end

	// Checks on the flag and timing behaviour
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	property p_fe_with_full;
		$rose(fe_f) |-> $rose(receiver_full_flag) || $past(clr);
	endproperty
	a_fe_with_full: assert property (p_fe_with_full) else $error("framing flag rose apart from full flag"); // RULE3

	property p_standby_mute;
		receiver_wakeup_bit |=> !IRQ_RX && !IRQ_ERR;
	endproperty
	a_standby_mute: assert property (p_standby_mute) else $error("interrupt raised in standby"); // RULE7

	property p_stop_mute;
		STOP_MODE |=> !IRQ_RX && !IRQ_ERR;
	endproperty
	a_stop_mute: assert property (p_stop_mute) else $error("interrupt raised in stop mode"); // RULE19

	property p_overrun_keeps;
		take && receiver_full_flag && !clr |=> ovr_f && $stable(data_reg);
	endproperty
	a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun changed data"); // RULE14

	property p_full_irq;
		receiver_full_flag && rie && !receiver_wakeup_bit && !STOP_MODE |=> IRQ_RX;
	endproperty
	a_full_irq: assert property (p_full_irq) else $error("full flag gave no request"); // RULE12

	property p_stop_time;
		st == SRX_CHAR && tick && run && !resync && !resynced && bitn == nbits + 4'h1 && rt_n == RT_S3
			|-> tick_cnt + 8'h01 == (mode9 ? STOP_T9 : STOP_T8);
	endproperty
	a_stop_time: assert property (p_stop_time) else $error("stop bit sampled at wrong tick"); // RULE6

	property p_idle_wake;
		idle_wake && !wr_ok |=> !receiver_wakeup_bit && !$rose(idle_f) && !$rose(receiver_full_flag);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake set a flag"); // RULE9

	property p_break_protect;
		DBG_BREAK && !BREAK_CLEAR_ENABLE ##1 1 |-> !$fell(receiver_full_flag) && !$fell(fe_f) && !$fell(noise_f);
	endproperty
	a_break_protect: assert property (p_break_protect) else $error("flag cleared in protected break"); // RULE21

	property p_mark_wake;
		ch_done && receiver_wakeup_bit && wake && ch_msb && !wr_ok |=> !receiver_wakeup_bit && receiver_full_flag;
	endproperty
	a_mark_wake: assert property (p_mark_wake) else $error("address mark did not wake"); // RULE8

	c_char: cover property (ch_done && !ch_fe && !ch_nf);
	c_break: cover property (ch_done && ch_brk);
	c_overrun: cover property ($rose(ovr_f));
	c_idle: cover property ($rose(idle_f));
endmodule // srx_top

/* common/srx_pkg.sv */
// Constants for the receive status block: register map, field positions,
// reset values and sample-clock timing.
// Assumes a 32-bit AXI4-Lite bus with byte addresses.
package srx_pkg;
	// Register byte offsets
	localparam logic [4:0] ADDR_CTRL1  = 5'h00;
	localparam logic [4:0] ADDR_CTRL2  = 5'h04;
	localparam logic [4:0] ADDR_CTRL3  = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0C;
	localparam logic [4:0] ADDR_DATA   = 5'h10;
	localparam logic [4:0] ADDR_BAUD   = 5'h14;
	// Control one fields
	localparam int C1_ENABLE = 0;
	localparam int C1_MODE9  = 1;
	localparam int C1_WAKE   = 2;
	localparam int C1_IDLE_LINE_TYPE_BIT   = 3;
	localparam int C1_PEN    = 4;
	localparam int C1_PTY    = 5;
	// Control two fields
	localparam int C2_RIE  = 0;
	localparam int C2_IDLE_INTERRUPT_ENABLE = 1;
	localparam int C2_RE   = 2;
	localparam int C2_RWU  = 3;
	// Control three fields
	localparam int C3_OVERRUN_INTERRUPT_ENABLE = 0;
	localparam int C3_NOISE_INTERRUPT_ENABLE = 1;
	localparam int C3_FRAMING_ERROR_INTERRUPT_ENABLE = 2;
	localparam int C3_PARITY_ERROR_INTERRUPT_ENABLE = 3;
	localparam int C3_R8   = 7;
	// Status one fields
	localparam int S1_FULL  = 0;
	localparam int S1_IDLE  = 1;
	localparam int S1_OVR   = 2;
	localparam int S1_NOISE = 3;
	localparam int S1_FRAME = 4;
	localparam int S1_PAR   = 5;
	// Reset values
	localparam logic [15:0] BAUD_RST = 16'h006C;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// Sample clock timing in sample ticks, idle thresholds in bit times
	localparam logic [4:0] RT_PER_BIT = 5'h10;
	localparam logic [4:0] RT_V1 = 5'h03;
	localparam logic [4:0] RT_V2 = 5'h05;
	localparam logic [4:0] RT_V3 = 5'h07;
	localparam logic [4:0] RT_S1 = 5'h08;
	localparam logic [4:0] RT_S3 = 5'h0A;
	localparam logic [7:0] STOP_T8 = 8'h9A;
	localparam logic [7:0] STOP_T9 = 8'hAA;
	localparam logic [3:0] IDLE_BITS8 = 4'hA;
	localparam logic [3:0] IDLE_BITS9 = 4'hB;
	typedef enum logic {SRX_HUNT, SRX_CHAR} srx_state_t;
endpackage

/* dv/srx_tx_model.sv */
// Model of the remote transmitter that drives the receive line.
// Assumes send() is called just after a rising clock edge.
`timescale 1ns/1ps
module srx_tx_model (
	input  wire logic clk,  // Bench clock
	output logic      line  // Receive line, idle high
);
	// Line rests at the idle level between frames
	initial line = 1'b1;

	// Start, LSB-first data, stop; per is clocks a bit, glitch dips the stop bit
	task automatic send(input logic [8:0] data, input int nbits, input logic stop, input int per,
		input logic glitch);
		int i;
		line <= 1'b0;
		repeat (per) @(posedge clk);
		for (i = 0; i < nbits; i++) begin
			line <= data[i];
			repeat (per) @(posedge clk);
		end
		line <= stop;
		repeat (8) @(posedge clk);
		line <= stop ^ glitch;
		@(posedge clk);
		line <= stop;
		repeat (per - 9) @(posedge clk);
		line <= 1'b1;
		@(posedge clk);
	endtask
endmodule // srx_tx_model

/* dv/async_serial_receiver_status_test.sv */
// Self-checking bench for the receive status block: bus tasks, a remote
// transmitter model and directed receive scenarios.
// Assumes baud divisor 0, so the sample clock ticks every system clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
	samples_checked++; \
	if ((got) !== (ex)) begin \
		fail_count++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
	end \
end
module async_serial_receiver_status_test import srx_pkg::*; ;
	logic        clk, arst_n, line, wait_mode, stop_mode, dbg_break, bce;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq_rx, irq_err;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, resp;
	int          fail_count = 0;
	int          samples_checked = 0;

	// System clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Remote transmitter and design
	srx_tx_model tx (
		.clk  (clk),
		.line (line)
	);
	srx_top dut (
		.CLK_SYS            (clk),
		.ARST_N             (arst_n),
		.RECEIVE_LINE_PIN   (line),
		.WAIT_MODE          (wait_mode),
		.STOP_MODE          (stop_mode),
		.DBG_BREAK          (dbg_break),
		.BREAK_CLEAR_ENABLE (bce),
		.S_AXI_AWVALID      (awvalid),
		.S_AXI_AWREADY      (awready),
		.S_AXI_AWADDR       (awaddr),
		.S_AXI_WVALID       (wvalid),
		.S_AXI_WREADY       (wready),
		.S_AXI_WDATA        (wdata),
		.S_AXI_WSTRB        (4'hF),
		.S_AXI_BVALID       (bvalid),
		.S_AXI_BREADY       (bready),
		.S_AXI_BRESP        (bresp),
		.S_AXI_ARVALID      (arvalid),
		.S_AXI_ARREADY      (arready),
		.S_AXI_ARADDR       (araddr),
		.S_AXI_RVALID       (rvalid),
		.S_AXI_RREADY       (rready),
		.S_AXI_RDATA        (rdata),
		.S_AXI_RRESP        (rresp),
		.IRQ_RX             (irq_rx),
		.IRQ_ERR            (irq_err)
	);

	// Bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	// Bus read: result lands in rd and resp
	task automatic rdr(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// Status then data read clears every flag, except in a break without clear enable
	task automatic clr();
		rdr(ADDR_STATUS);
		rdr(ADDR_DATA);
	endtask

	task automatic ended(input string s);
		$display("test %s finished", s);
	endtask

	// One 8-bit character, then interrupts, status and data compared
	task automatic rxc(input logic [8:0] d, input logic stp, input int per, input logic gl,
		input logic [7:0] st);
		clr();
		tx.send(d, 8, stp, per, gl);
		`CHK("receive irq", st[0], irq_rx)
		`CHK("error irq", |st[5:2], irq_err)
		rdr(ADDR_STATUS);
		`CHK("status", {24'h000000, st}, rd)
		rdr(ADDR_DATA);
		`CHK("data", {24'h000000, d[7:0]}, rd)
	endtask

	// Receive interrupt must be low before the stop sample and high after it
	task automatic timed(input logic [8:0] d, input int nb, input int t0);
		clr();
		fork
			tx.send(d, nb, 1'b1, 16, 1'b0);
			begin
				repeat (t0) @(posedge clk);
				`CHK("irq before stop", 1'b0, irq_rx)
				repeat (2) @(posedge clk);
				`CHK("irq after stop", 1'b1, irq_rx)
			end
		join
		rdr(ADDR_STATUS);
		`CHK("timed status", 32'h00000001, rd)
		rdr(ADDR_DATA);
		`CHK("timed data", 32'h000000A5, rd)
		rdr(ADDR_CTRL3);
		`CHK("ninth bit", 32'h0000008F, rd)
	endtask

	// Idle flag must stay clear until tno and be set some bit times later
	task automatic idlechk(input logic idle_line_type_bit, input int tno);
		wr(ADDR_CTRL1, {28'h0000000, idle_line_type_bit, 3'h1});
		clr();
		tx.send(9'h000, 8, 1'b1, 16, 1'b0);
		clr();
		repeat (tno) @(posedge clk);
		rdr(ADDR_STATUS);
		`CHK("idle not yet", 32'h00000000, rd)
		repeat (40) @(posedge clk);
		rdr(ADDR_STATUS);
		`CHK("idle set", 32'h00000002, rd)
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		summarize();
	end

	// Directed scenarios
	initial begin
		arst_n = 1'b0;
		{wait_mode, stop_mode, dbg_break, bce} = 4'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h00000000;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rdr(ADDR_BAUD);
		`CHK("baud reset", {16'h0000, BAUD_RST}, rd)
		rdr(5'h18);
		`CHK("unmapped read", RESP_SLVERR, resp)
		wr(5'h18, 32'h00000000);
		`CHK("unmapped write", RESP_SLVERR, resp)
		wr(ADDR_BAUD, 32'h00000000);
		wr(ADDR_CTRL1, 32'h00000001);
		wr(ADDR_CTRL2, 32'h00000005);
		wr(ADDR_CTRL3, 32'h0000000F);
		ended("registers");
		timed(9'h0A5, 8, 155);
		wr(ADDR_CTRL1, 32'h00000003);
		timed(9'h1A5, 9, 171);
		wr(ADDR_CTRL1, 32'h00000001);
		ended("stop timing");
		rxc(9'h0C3, 1'b0, 16, 1'b0, 8'h11);
		rxc(9'h000, 1'b0, 16, 1'b0, 8'h11);
		rxc(9'h03C, 1'b1, 16, 1'b1, 8'h09);
		rxc(9'h055, 1'b1, 18, 1'b0, 8'h01);
		wr(ADDR_CTRL1, 32'h00000011);
		rxc(9'h001, 1'b1, 16, 1'b0, 8'h21);
		rxc(9'h081, 1'b1, 16, 1'b0, 8'h01);
		wr(ADDR_CTRL1, 32'h00000031);
		rxc(9'h081, 1'b1, 16, 1'b0, 8'h21);
		wr(ADDR_CTRL1, 32'h00000001);
		clr();
		tx.send(9'h011, 8, 1'b1, 16, 1'b0);
		tx.send(9'h022, 8, 1'b1, 16, 1'b0);
		`CHK("overrun irq", 1'b1, irq_err)
		rdr(ADDR_STATUS);
		`CHK("overrun status", 32'h00000005, rd)
		rdr(ADDR_DATA);
		`CHK("overrun data", 32'h00000011, rd)
		ended("character errors");
		wr(ADDR_CTRL1, 32'h00000005);
		wr(ADDR_CTRL2, 32'h0000000D);
		tx.send(9'h012, 8, 1'b1, 16, 1'b0);
		`CHK("standby irq", 1'b0, irq_rx)
		rdr(ADDR_STATUS);
		`CHK("standby status", 32'h00000000, rd)
		tx.send(9'h092, 8, 1'b1, 16, 1'b0);
		rdr(ADDR_CTRL2);
		`CHK("mark wake", 32'h00000005, rd)
		clr();
		`CHK("mark data", 32'h00000092, rd)
		wr(ADDR_CTRL1, 32'h00000001);
		fork
			tx.send(9'h000, 8, 1'b1, 16, 1'b0);
			begin
				repeat (40) @(posedge clk);
				wr(ADDR_CTRL2, 32'h0000000D);
			end
		join
		repeat (200) @(posedge clk);
		rdr(ADDR_CTRL2);
		`CHK("idle wake", 32'h00000005, rd)
		rdr(ADDR_STATUS);
		`CHK("idle wake status", 32'h00000000, rd)
		wr(ADDR_CTRL2, 32'h0000000D);
		rdr(ADDR_CTRL2);
		`CHK("wake on idle line", 32'h00000005, rd)
		ended("wakeup");
		wait_mode <= 1'b1;
		rdr(ADDR_STATUS);
		`CHK("wait read", RESP_SLVERR, resp)
		wr(ADDR_CTRL2, 32'h00000000);
		`CHK("wait write", RESP_SLVERR, resp)
		tx.send(9'h05A, 8, 1'b1, 16, 1'b0);
		`CHK("wait irq", 1'b1, irq_rx)
		wait_mode <= 1'b0;
		rdr(ADDR_CTRL2);
		`CHK("wait write ignored", 32'h00000005, rd)
		clr();
		`CHK("wait data", 32'h0000005A, rd)
		wr(ADDR_CTRL1, 32'h00000000);
		wait_mode <= 1'b1;
		tx.send(9'h05A, 8, 1'b1, 16, 1'b0);
		`CHK("disabled in wait irq", 1'b0, irq_rx)
		wait_mode <= 1'b0;
		wr(ADDR_CTRL1, 32'h00000001);
		rdr(ADDR_STATUS);
		`CHK("disabled in wait status", 32'h00000000, rd)
		tx.send(9'h033, 8, 1'b1, 16, 1'b0);
		stop_mode <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("stop irq", 1'b0, irq_rx)
		tx.send(9'h044, 8, 1'b1, 16, 1'b0);
		stop_mode <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("resume irq", 1'b1, irq_rx)
		rdr(ADDR_STATUS);
		`CHK("stop status kept", 32'h00000001, rd)
		rdr(ADDR_DATA);
		`CHK("stop data kept", 32'h00000033, rd)
		tx.send(9'h066, 8, 1'b1, 16, 1'b0);
		dbg_break <= 1'b1;
		clr();
		rdr(ADDR_STATUS);
		`CHK("break protect", 32'h00000001, rd)
		dbg_break <= 1'b0;
		rdr(ADDR_STATUS);
		dbg_break <= 1'b1;
		rdr(ADDR_DATA);
		rdr(ADDR_STATUS);
		`CHK("armed in break", 32'h00000001, rd)
		dbg_break <= 1'b0;
		rdr(ADDR_DATA);
		rdr(ADDR_STATUS);
		`CHK("second step", 32'h00000000, rd)
		tx.send(9'h077, 8, 1'b1, 16, 1'b0);
		dbg_break <= 1'b1;
		bce <= 1'b1;
		clr();
		dbg_break <= 1'b0;
		rdr(ADDR_STATUS);
		`CHK("break clear sticks", 32'h00000000, rd)
		ended("low power and break");
		wr(ADDR_CTRL2, 32'h00000007);
		idlechk(1'b0, 110);
		idlechk(1'b1, 138);
		`CHK("idle irq", 1'b1, irq_rx)
		ended("idle");
		summarize();
	end
endmodule // async_serial_receiver_status_test
